// ==== qsr_pkg.sv ====
// package of register map, field positions and reset values for status tree
package qsr_pkg;
	// ==========================================================
	// geometry
	localparam int          NUM_GRP      = 5;
	localparam int          GRP_W        = 16;
	localparam int          ERR_DEPTH    = 8;
	localparam int          ERR_PTR_W    = 3;
	localparam int          ERR_NUM_W    = 16;
	localparam int          ERR_TXT_W    = 16;
	// ==========================================================
	// group indices
	localparam logic [2:0]  GRP_TOP      = 3'h0;
	localparam logic [2:0]  GRP_SOUND    = 3'h1;
	localparam logic [2:0]  GRP_HWSOUND  = 3'h2;
	localparam logic [2:0]  GRP_LIM1     = 3'h3;
	localparam logic [2:0]  GRP_LIM2     = 3'h4;
	// ==========================================================
	// summary bit positions in parent registers
	localparam int          POS_LIM1_TOP = 10;
	localparam int          POS_LIM2_L1  = 0;
	localparam int          POS_HW_SOUND = 1;
	localparam int          POS_SND_TOP  = 9;
	// ==========================================================
	// per-group register block: byte address = group*0x20 + field offset
	localparam logic [7:0]  OFS_COND     = 8'h00;
	localparam logic [7:0]  OFS_EVENT    = 8'h04;
	localparam logic [7:0]  OFS_ENABLE   = 8'h08;
	localparam logic [7:0]  OFS_RISE     = 8'h0C;
	localparam logic [7:0]  OFS_FALL     = 8'h10;
	localparam int          GRP_SHIFT    = 5;
	// ==========================================================
	// global registers
	localparam logic [7:0]  ADR_CTRL     = 8'hA0;
	localparam logic [7:0]  ADR_QUEUE    = 8'hA4;
	localparam logic [7:0]  ADR_PUSH     = 8'hA8;
	localparam logic [7:0]  ADR_IRQ_STAT = 8'hAC;
	localparam logic [7:0]  ADR_IRQ_MASK = 8'hB0;
	localparam logic [7:0]  ADR_QCNT     = 8'hB4;
	localparam int          CTRL_CLS     = 0;
	localparam int          CTRL_PRESET  = 1;
	localparam int          CTRL_RST     = 2;
	localparam int          CTRL_QEN     = 3;
	// ==========================================================
	// reset and preset values
	localparam logic [15:0] ENABLE_RST   = 16'h0000;
	localparam logic [15:0] RISE_RST     = 16'hFFFF;
	localparam logic [15:0] FALL_RST     = 16'h0000;
	localparam logic [15:0] ENABLE_PRE   = 16'hFFFF;
	localparam logic [15:0] RISE_PRE     = 16'hFFFF;
	localparam logic [15:0] FALL_PRE     = 16'h0000;
	localparam logic [15:0] NO_ERR_NUM   = 16'h0000;
	localparam logic [15:0] NO_ERR_TXT   = 16'h4E45;
	// interrupt bits
	localparam int          IRQ_SUMMARY  = 0;
	localparam int          IRQ_QOVF     = 1;
	localparam int          IRQ_QNONEMP  = 2;
	localparam int          IRQ_W        = 3;
endpackage : qsr_pkg

// ==== qsr_group.sv ====
// one status group: condition, edge filters, event latch, enable, summary
`timescale 1ns/100ps
module qsr_group (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [15:0] condIn,
	input  wire logic        clsPulse,
	input  wire logic        presetPulse,
	input  wire logic        evtReadClr,
	input  wire logic        wrEnable,
	input  wire logic        wrRise,
	input  wire logic        wrFall,
	input  wire logic [15:0] wrData,
	output logic      [15:0] cond,
	output logic      [15:0] event_r,
	output logic      [15:0] enable_r,
	output logic      [15:0] rise_r,
	output logic      [15:0] fall_r,
	output logic             summary
);
	logic [15:0] condPrev_r;
	logic [15:0] newEvt;

	// ==========================================================
	// edge detection through filters
	assign cond    = condIn;
	assign newEvt  = (rise_r & condIn & ~condPrev_r)
	               | (fall_r & ~condIn & condPrev_r);
	assign summary = |(event_r & enable_r);

	// previous condition for edge detection
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			condPrev_r <= 16'h0000;
		end else begin
			condPrev_r <= condIn;
		end
	end

	// event latch; read-clear and clear-status lose to a new event
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			event_r <= 16'h0000;
		end else if (clsPulse || evtReadClr) begin
			event_r <= newEvt;
		end else begin
			event_r <= event_r | newEvt;
		end
	end

	// masks and filters; preset touches only these
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			enable_r <= qsr_pkg::ENABLE_RST;
			rise_r   <= qsr_pkg::RISE_RST;
			fall_r   <= qsr_pkg::FALL_RST;
		end else if (presetPulse) begin
			enable_r <= qsr_pkg::ENABLE_PRE;
			rise_r   <= qsr_pkg::RISE_PRE;
			fall_r   <= qsr_pkg::FALL_PRE;
		end else begin
			if (wrEnable) enable_r <= wrData;
			if (wrRise)   rise_r   <= wrData;
			if (wrFall)   fall_r   <= wrData;
		end
	end
endmodule // qsr_group

// ==== qsr_err_queue.sv ====
// error queue: oldest-first, destructive read, number-zero no-error-text entry when empty
`timescale 1ns/100ps
module qsr_err_queue (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [15:0] pushNum,
	input  wire logic [15:0] pushTxt,
	input  wire logic        pop,
	output logic      [15:0] headNum,
	output logic      [15:0] headTxt,
	output logic      [3:0]  count,
	output logic             overflow
);
	logic [15:0] numMem [qsr_pkg::ERR_DEPTH];
	logic [15:0] txtMem [qsr_pkg::ERR_DEPTH];
	logic [2:0]  rdPtr_r;
	logic [2:0]  wrPtr_r;
	logic [3:0]  cnt_r;
	logic        doPush;
	logic        doPop;

	assign count    = cnt_r;
	assign doPop    = pop && (cnt_r != 4'h0);
	assign doPush   = push && (cnt_r != 4'h8 || doPop);
	assign overflow = push && !doPush;
	// empty queue reports number zero and the no-error text
	assign headNum  = (cnt_r == 4'h0) ? qsr_pkg::NO_ERR_NUM
	                                  : numMem[rdPtr_r];
	assign headTxt  = (cnt_r == 4'h0) ? qsr_pkg::NO_ERR_TXT
	                                  : txtMem[rdPtr_r];

	// storage
	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			numMem[wrPtr_r] <= pushNum;
			txtMem[wrPtr_r] <= pushTxt;
		end
	end

	// pointers and fill level
	always_ff @(posedge sys_clk) begin
		if (!resetn || flush) begin
			rdPtr_r <= 3'h0;
			wrPtr_r <= 3'h0;
			cnt_r   <= 4'h0;
		end else begin
			if (doPush) wrPtr_r <= wrPtr_r + 3'h1;
			if (doPop)  rdPtr_r <= rdPtr_r + 3'h1;
			cnt_r <= cnt_r + {3'h0, doPush} - {3'h0, doPop};
		end
	end
endmodule // qsr_err_queue

// ==== qsr_status_top.sv ====
// status tree top: five groups, error queue, AHB-Lite register slave
// Function
// - instrument reset command leaves status registers unchanged, except queue enable, which a CTRL write without the preset bit loads from bit 3
// - preset changes only filters, enables and queue enabling
// - preset loads every enable mask with all ones
// - preset sets rising filters to ones, falling filters to zeros
// - condition read returns live bits and changes nothing
// - event read returns latched bits and clears the event register
// - rising filter bit latches a zero-to-one condition change
// - falling filter bit latches a one-to-zero condition change
// - enabled event raises the summary bit in the parent register
// - limit-one summary feeds top bit 10; limit-two feeds limit-one bit 0
// - masks and filters are sixteen-bit writable registers
// - two independent limit-check groups, selected by index one or two
// - each group has separate condition and event parts
// - queue read returns oldest entry and removes it
// - queue entry holds signed error number and short text code
// - empty queue read returns number zero and no-error text
`timescale 1ns/100ps
module qsr_status_top (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic [15:0] doubtfulCondIn,
	input  wire logic [15:0] soundnessCondIn,
	input  wire logic [15:0] hwSoundnessCondIn,
	input  wire logic [15:0] limit1CondIn,
	input  wire logic [15:0] limit2CondIn,
	output logic             summaryOut,
	output logic             irq
);
	// ==========================================================
	// synchronise condition inputs: three stages, agree on 2 and 3
	logic [79:0] condRaw;
	logic [79:0] sync1_r;
	logic [79:0] sync2_r;
	logic [79:0] sync3_r;
	logic [79:0] condStable_r;

	assign condRaw = {limit2CondIn, limit1CondIn, hwSoundnessCondIn,
	                  soundnessCondIn, doubtfulCondIn};

	// synchroniser chain
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sync1_r <= 80'h0;
			sync2_r <= 80'h0;
			sync3_r <= 80'h0;
		end else begin
			sync1_r <= condRaw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// accept a bit change only when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			condStable_r <= 80'h0;
		end else begin
			condStable_r <= (sync2_r & sync3_r)
			              | (condStable_r & (sync2_r | sync3_r));
		end
	end

	// ==========================================================
	// AHB-Lite address phase capture
	logic        apValid;
	logic        dpValid_r;
	logic        dpWrite_r;
	logic [7:0]  dpAddr_r;
	logic [2:0]  dpGrp;
	logic [7:0]  dpOfs;
	logic        dpHit;

	assign apValid = hsel && hready && htrans[1];
	assign dpGrp   = dpAddr_r[7:5];
	assign dpOfs   = {3'h0, dpAddr_r[4:0]};
	assign dpHit   = (dpGrp < 3'h5) && (dpOfs <= qsr_pkg::OFS_FALL);

	// latch address phase; slave answers with zero wait states
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dpValid_r <= 1'b0;
			dpWrite_r <= 1'b0;
			dpAddr_r  <= 8'h00;
		end else begin
			dpValid_r <= apValid;
			if (apValid) begin
				dpWrite_r <= hwrite;
				dpAddr_r  <= haddr[7:0];
			end
		end
	end

	// response is always OKAY with no wait states
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ==========================================================
	// decoded strobes
	logic        wrStrobe;
	logic        rdStrobe;
	logic        apRead;
	logic [7:0]  apAddr;
	logic        clsPulse;
	logic        presetPulse;
	logic        qEnable_r;

	assign wrStrobe    = dpValid_r && dpWrite_r;
	assign apRead      = apValid && !hwrite;
	assign apAddr      = haddr[7:0];
	assign rdStrobe    = apRead;
	assign clsPulse    = wrStrobe && (dpAddr_r == qsr_pkg::ADR_CTRL)
	                     && hwdata[qsr_pkg::CTRL_CLS];
	assign presetPulse = wrStrobe && (dpAddr_r == qsr_pkg::ADR_CTRL)
	                     && hwdata[qsr_pkg::CTRL_PRESET];
	// the instrument reset bit has no effect on status state
	// (CTRL_RST is accepted and deliberately ignored)

	// queue enable, set by preset (queue enabling), writable
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			qEnable_r <= 1'b1;
		end else if (presetPulse) begin
			qEnable_r <= 1'b1;
		end else if (wrStrobe && dpAddr_r == qsr_pkg::ADR_CTRL) begin
			qEnable_r <= hwdata[qsr_pkg::CTRL_QEN];
		end
	end

	// ==========================================================
	// the five groups and their summary wiring
	logic [15:0] gCondIn [5];
	logic [15:0] gCond   [5];
	logic [15:0] gEvent  [5];
	logic [15:0] gEnable [5];
	logic [15:0] gRise   [5];
	logic [15:0] gFall   [5];
	logic [4:0]  gSum;

	// summaries feed the parent condition bits
	always_comb begin
		gCondIn[0] = condStable_r[15:0];
		gCondIn[1] = condStable_r[31:16];
		gCondIn[2] = condStable_r[47:32];
		gCondIn[3] = condStable_r[63:48];
		gCondIn[4] = condStable_r[79:64];
		gCondIn[0][qsr_pkg::POS_LIM1_TOP] = gSum[3];
		gCondIn[3][qsr_pkg::POS_LIM2_L1]  = gSum[4];
		gCondIn[1][qsr_pkg::POS_HW_SOUND] = gSum[2];
		gCondIn[0][qsr_pkg::POS_SND_TOP]  = gSum[1];
	end

	// one instance per group, each with its own parts
	for (genvar g = 0; g < qsr_pkg::NUM_GRP; g++) begin : gen_grp
		logic sel;
		assign sel = wrStrobe && dpHit && (dpAddr_r[7:5] == 3'(g));
		qsr_group u_grp (
			.sys_clk     (sys_clk),
			.resetn      (resetn),
			.condIn      (gCondIn[g]),
			.clsPulse    (clsPulse),
			.presetPulse (presetPulse),
			.evtReadClr  (rdStrobe && apAddr[7:5] == 3'(g)
			              && {3'h0, apAddr[4:0]} == qsr_pkg::OFS_EVENT),
			.wrEnable    (sel && dpOfs == qsr_pkg::OFS_ENABLE),
			.wrRise      (sel && dpOfs == qsr_pkg::OFS_RISE),
			.wrFall      (sel && dpOfs == qsr_pkg::OFS_FALL),
			.wrData      (hwdata[15:0]),
			.cond        (gCond[g]),
			.event_r     (gEvent[g]),
			.enable_r    (gEnable[g]),
			.rise_r      (gRise[g]),
			.fall_r      (gFall[g]),
			.summary     (gSum[g])
		);
	end

	// ==========================================================
	// error queue
	logic        qPush;
	logic        qPop;
	logic [15:0] qNum;
	logic [15:0] qTxt;
	logic [3:0]  qCount;
	logic        qOvf;

	assign qPush = wrStrobe && (dpAddr_r == qsr_pkg::ADR_PUSH) && qEnable_r;
	assign qPop  = apRead && (apAddr == qsr_pkg::ADR_QUEUE);

	qsr_err_queue u_queue (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.flush    (clsPulse),
		.push     (qPush),
		.pushNum  (hwdata[31:16]),
		.pushTxt  (hwdata[15:0]),
		.pop      (qPop),
		.headNum  (qNum),
		.headTxt  (qTxt),
		.count    (qCount),
		.overflow (qOvf)
	);

	// ==========================================================
	// interrupts: sticky status, write one to clear, set wins
	logic [2:0] irqEvt;
	logic [2:0] irqStat_r;
	logic [2:0] irqMask_r;
	logic       sumPrev_r;
	logic       irqClrWr;

	assign irqEvt   = {qPush, qOvf, gSum[0] & ~sumPrev_r};
	assign irqClrWr = wrStrobe && (dpAddr_r == qsr_pkg::ADR_IRQ_STAT);

	// sticky status bits
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irqStat_r <= 3'h0;
			sumPrev_r <= 1'b0;
		end else begin
			sumPrev_r <= gSum[0];
			irqStat_r <= (irqStat_r & ~(irqClrWr ? hwdata[2:0] : 3'h0))
			           | irqEvt;
		end
	end

	// mask register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irqMask_r <= 3'h0;
		end else if (wrStrobe && dpAddr_r == qsr_pkg::ADR_IRQ_MASK) begin
			irqMask_r <= hwdata[2:0];
		end
	end

	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irq        <= 1'b0;
			summaryOut <= 1'b0;
		end else begin
			irq        <= |(irqStat_r & irqMask_r);
			summaryOut <= gSum[0];
		end
	end

	// ==========================================================
	// read data, sampled in the address phase so reads see pre-clear state
	logic [31:0] rdNxt;
	logic [2:0]  aGrp;
	logic [7:0]  aOfs;

	assign aGrp = apAddr[7:5];
	assign aOfs = {3'h0, apAddr[4:0]};

	// read multiplexer
	always_comb begin
		rdNxt = 32'h0000_0000;
		if (aGrp < 3'h5) begin
			case (aOfs)
				qsr_pkg::OFS_COND:   rdNxt = {16'h0000, gCond[aGrp]};
				qsr_pkg::OFS_EVENT:  rdNxt = {16'h0000, gEvent[aGrp]};
				qsr_pkg::OFS_ENABLE: rdNxt = {16'h0000, gEnable[aGrp]};
				qsr_pkg::OFS_RISE:   rdNxt = {16'h0000, gRise[aGrp]};
				qsr_pkg::OFS_FALL:   rdNxt = {16'h0000, gFall[aGrp]};
				default:             rdNxt = 32'h0000_0000;
			endcase
		end else begin
			case (apAddr)
				qsr_pkg::ADR_CTRL:
					rdNxt = {28'h000_0000, qEnable_r, 3'h0};
				qsr_pkg::ADR_QUEUE:    rdNxt = {qNum, qTxt};
				qsr_pkg::ADR_IRQ_STAT: rdNxt = {29'h0, irqStat_r};
				qsr_pkg::ADR_IRQ_MASK: rdNxt = {29'h0, irqMask_r};
				qsr_pkg::ADR_QCNT:     rdNxt = {28'h000_0000, qCount};
				default:               rdNxt = 32'h0000_0000;
			endcase
		end
	end

	// read data register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (apRead) begin
			hrdata <= rdNxt;
		end
	end
endmodule // qsr_status_top

// ==== qsr_status_chk.sv ====
// checker of bus and status relations seen at the status tree top ports
`timescale 1ns/100ps
module qsr_status_chk (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] doubtfulCondIn,
	input wire logic [15:0] soundnessCondIn,
	input wire logic [15:0] hwSoundnessCondIn,
	input wire logic [15:0] limit1CondIn,
	input wire logic [15:0] limit2CondIn,
	input wire logic        summaryOut,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// helper: taken requests and mirrors of top enable and irq mask
	logic        rdReq;
	logic        wrReq;
	logic        wPend_r;
	logic [7:0]  wAdr_r;
	logic [15:0] enMir_r;
	logic [2:0]  mskMir_r;
	assign rdReq = hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 0;
	assign wrReq = hsel && hready && htrans[1] && hwrite && haddr[31:8] == 0;
	// writes land at the data phase edge, as in the design
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wPend_r  <= 1'h0;
			enMir_r  <= qsr_pkg::ENABLE_RST;
			mskMir_r <= 3'h0; // interrupt mask clears on reset
		end else begin
			wPend_r <= wrReq;
			if (wPend_r && wAdr_r == qsr_pkg::OFS_ENABLE)
				enMir_r <= hwdata[15:0];
			if (wPend_r && wAdr_r == qsr_pkg::ADR_CTRL
				&& hwdata[qsr_pkg::CTRL_PRESET])
				enMir_r <= qsr_pkg::ENABLE_PRE;
			if (wPend_r && wAdr_r == qsr_pkg::ADR_IRQ_MASK)
				mskMir_r <= hwdata[2:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		wAdr_r <= haddr[7:0];
	end
	// ==========================================================
	// assertions
	a_reset_quiet: assert property (
		$rose(resetn) |-> !irq && !summaryOut && hrdata == 32'h0000_0000)
		else $error("outputs not quiet after reset");
	a_hold_rdata: assert property (
		!rdReq |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_cond_top: assert property (
		$stable(doubtfulCondIn)[*8] ##0 (rdReq && haddr[7:0] == 8'h00)
		|=> (hrdata[15:0] & 16'hF9FF) == ($past(doubtfulCondIn) & 16'hF9FF))
		else $error("top condition read not live");
	a_cond_hw: assert property (
		$stable(hwSoundnessCondIn)[*8] ##0 (rdReq && haddr[7:0] == 8'h40)
		|=> hrdata[15:0] == $past(hwSoundnessCondIn))
		else $error("hw condition read not live");
	a_cond_lim2: assert property (
		$stable(limit2CondIn)[*8] ##0 (rdReq && haddr[7:0] == 8'h80)
		|=> hrdata[15:0] == $past(limit2CondIn))
		else $error("limit two condition read not live");
	a_unmapped_zero: assert property (
		rdReq && haddr[7:0] > 8'hB4 |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_summary_masked: assert property (
		(enMir_r == 16'h0000)[*3] |-> !summaryOut)
		else $error("summary high with top enable clear");
	a_irq_masked: assert property (
		(mskMir_r == 3'h0)[*3] |-> !irq)
		else $error("irq high with mask clear");
endmodule // qsr_status_chk

bind qsr_status_top qsr_status_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .doubtfulCondIn(doubtfulCondIn),
	.soundnessCondIn(soundnessCondIn), .hwSoundnessCondIn(hwSoundnessCondIn),
	.limit1CondIn(limit1CondIn), .limit2CondIn(limit2CondIn),
	.summaryOut(summaryOut), .irq(irq));

// ==== qsr_host_model.sv ====
// remote host model: AHB-Lite single-word master of the status registers
`timescale 1ns/100ps
module qsr_host_model (
	input  wire logic        sys_clk,
	input  wire logic        hreadyIn,
	input  wire logic [31:0] hrdataIn,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	assign hsize = 3'h2; // whole words only
	initial begin
		haddr  = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0000_0000;
	end
	// limit group selected by index one or two
	function automatic logic [7:0] limBase(input int idx);
		return (idx == 1) ? 8'h60 : 8'h80;
	endfunction
	// one transfer; released lines show inverted values, not stale ones
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r, output bit tmo);
		int n;
		tmo = 1'b0;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyIn !== 1'b1 && n < 16);
		if (hreadyIn !== 1'b1)
			tmo = 1'b1;
		htrans <= 2'h0;
		haddr  <= ~a;
		hwdata <= w ? d : ~hwdata;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyIn !== 1'b1 && n < 16);
		if (hreadyIn !== 1'b1)
			tmo = 1'b1;
		r = hrdataIn;
		hwdata <= ~d;
	endtask
endmodule // qsr_host_model

// ==== qsr_status_top_tb.sv ====
// self-checking bench of the status tree top over its register bus
`timescale 1ns/100ps
module qsr_status_top_tb;
	logic        sys_clk;
	logic        resetn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [15:0] dbtCond;
	logic [15:0] sndCond;
	logic [15:0] hwCond;
	logic [15:0] l1Cond;
	logic [15:0] l2Cond;
	logic        summaryOut;
	logic        irq;
	int          failures;
	int          numChecks;

	qsr_host_model host (.sys_clk(sys_clk), .hreadyIn(hreadyout),
		.hrdataIn(hrdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));
	qsr_status_top DUT (.sys_clk(sys_clk), .resetn(resetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .doubtfulCondIn(dbtCond),
		.soundnessCondIn(sndCond), .hwSoundnessCondIn(hwCond),
		.limit1CondIn(l1Cond), .limit2CondIn(l2Cond),
		.summaryOut(summaryOut), .irq(irq));

	// ==========================================================
	// clock, verdict, compares and bus tasks
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		bit tmo;
		host.xfer(w, {24'h00_0000, a}, d, r, tmo);
		if (tmo) begin
			failures++;
			$display("BAD %0t bus never ready", $time);
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xf(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xf(1'b0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pollHigh(input bit useIrq);
		int n;
		n = 0;
		while ((useIrq ? irq : summaryOut) !== 1'b1 && n < 64) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 64) begin
			failures++;
			$display("BAD %0t flag never rose", $time);
			complete_run();
		end
	endtask
	function automatic logic [7:0] ga(input int g, input logic [7:0] ofs);
		return 8'(g << qsr_pkg::GRP_SHIFT) | ofs;
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		resetn = 1'b0;
		{dbtCond, sndCond, hwCond, l1Cond, l2Cond} = 80'h0;
		failures = 0;
		numChecks = 0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (int g = 0; g < qsr_pkg::NUM_GRP; g++) begin
			rdc(ga(g, qsr_pkg::OFS_ENABLE), 32'(qsr_pkg::ENABLE_RST));
			rdc(ga(g, qsr_pkg::OFS_RISE), 32'(qsr_pkg::RISE_RST));
			rdc(ga(g, qsr_pkg::OFS_FALL), 32'(qsr_pkg::FALL_RST));
			rdc(ga(g, qsr_pkg::OFS_EVENT), 32'h0000_0000);
		end
		$display("test reset values done");
		// live conditions, nondestructive reads
		dbtCond <= 16'h0011;
		sndCond <= 16'h0100;
		hwCond <= 16'h0004;
		idle(8);
		rdc(8'h00, 32'h0000_0011);
		rdc(8'h20, 32'h0000_0100);
		rdc(8'h40, 32'h0000_0004);
		rdc(8'h40, 32'h0000_0004);
		// boundary values in masks and filters
		for (int g = 0; g < qsr_pkg::NUM_GRP; g++) begin
			wr(ga(g, qsr_pkg::OFS_ENABLE), 32'hABCD_FFFF);
			wr(ga(g, qsr_pkg::OFS_RISE), 32'h0000_0000);
			wr(ga(g, qsr_pkg::OFS_FALL), 32'h0000_FFFF);
			rdc(ga(g, qsr_pkg::OFS_ENABLE), 32'h0000_FFFF);
			rdc(ga(g, qsr_pkg::OFS_RISE), 32'h0000_0000);
			rdc(ga(g, qsr_pkg::OFS_FALL), 32'h0000_FFFF);
		end
		$display("test conditions and filters done");
		// instrument reset then preset keep conditions and events
		wr(qsr_pkg::ADR_CTRL, 32'h0000_0004);
		wr(qsr_pkg::ADR_CTRL, 32'h0000_0002);
		for (int g = 0; g < qsr_pkg::NUM_GRP; g++) begin
			rdc(ga(g, qsr_pkg::OFS_ENABLE), 32'(qsr_pkg::ENABLE_PRE));
			rdc(ga(g, qsr_pkg::OFS_RISE), 32'(qsr_pkg::RISE_PRE));
			rdc(ga(g, qsr_pkg::OFS_FALL), 32'(qsr_pkg::FALL_PRE));
		end
		rdc(8'h40, 32'h0000_0004);
		rdc(8'h44, 32'h0000_0004);
		rdc(8'h44, 32'h0000_0000);
		// falling filter latches, cleared rising filter does not
		wr(ga(2, qsr_pkg::OFS_FALL), 32'h0000_0004);
		wr(ga(2, qsr_pkg::OFS_RISE), 32'h0000_0000);
		hwCond <= 16'h0000;
		idle(8);
		rdc(8'h44, 32'h0000_0004);
		hwCond <= 16'h0004;
		idle(8);
		rdc(8'h44, 32'h0000_0000);
		wr(qsr_pkg::ADR_CTRL, 32'h0000_0001);
		idle(4);
		rdc(8'h04, 32'h0000_0000);
		chkb(summaryOut, 1'b0);
		$display("test preset and edges done");
		// limit two feeds limit one bit 0, limit one feeds top bit 10
		l1Cond <= 16'h8000;
		l2Cond <= 16'h0008;
		pollHigh(1'b0);
		chkb(summaryOut, 1'b1);
		rdc(8'h04, 32'h0000_0400);
		rdc(host.limBase(1) + 8'h04, 32'h0000_8001);
		rdc(host.limBase(2) + 8'h04, 32'h0000_0008);
		rdc(host.limBase(2), 32'h0000_0008);
		idle(4);
		chkb(summaryOut, 1'b0);
		rdc(host.limBase(1), 32'h0000_8000);
		$display("test hierarchy done");
		// interrupt masked, unmasked and cleared
		wr(qsr_pkg::ADR_IRQ_MASK, 32'h0000_0000);
		idle(4);
		chkb(irq, 1'b0);
		wr(qsr_pkg::ADR_IRQ_MASK, 32'h0000_0001);
		pollHigh(1'b1);
		chkb(irq, 1'b1);
		wr(qsr_pkg::ADR_IRQ_STAT, 32'h0000_0007);
		idle(4);
		chkb(irq, 1'b0);
		rdc(qsr_pkg::ADR_IRQ_STAT, 32'h0000_0000);
		$display("test interrupt done");
		// error queue: empty entry, order, sign, overflow, flush
		wr(qsr_pkg::ADR_CTRL, 32'h0000_0008);
		rdc(qsr_pkg::ADR_QUEUE, {qsr_pkg::NO_ERR_NUM, qsr_pkg::NO_ERR_TXT});
		wr(qsr_pkg::ADR_PUSH, 32'h0001_0011);
		wr(qsr_pkg::ADR_PUSH, 32'hFFFE_0022);
		wr(qsr_pkg::ADR_PUSH, 32'h0003_0033);
		rdc(qsr_pkg::ADR_QCNT, 32'h0000_0003);
		rdc(qsr_pkg::ADR_QUEUE, 32'h0001_0011);
		rdc(qsr_pkg::ADR_QUEUE, 32'hFFFE_0022);
		rdc(qsr_pkg::ADR_QUEUE, 32'h0003_0033);
		rdc(qsr_pkg::ADR_QUEUE, {qsr_pkg::NO_ERR_NUM, qsr_pkg::NO_ERR_TXT});
		for (int i = 0; i <= qsr_pkg::ERR_DEPTH; i++)
			wr(qsr_pkg::ADR_PUSH, {16'(i + 1), 16'h00A0});
		rdc(qsr_pkg::ADR_QCNT, 32'(qsr_pkg::ERR_DEPTH));
		rdc(qsr_pkg::ADR_IRQ_STAT, 32'h0000_0006);
		rdc(qsr_pkg::ADR_QUEUE, 32'h0001_00A0);
		wr(qsr_pkg::ADR_CTRL, 32'h0000_0009);
		rdc(qsr_pkg::ADR_QCNT, 32'h0000_0000);
		$display("test error queue done");
		// unmapped places read zero and ignore writes
		wr(8'hFC, 32'hFFFF_FFFF);
		rdc(8'hFC, 32'h0000_0000);
		rdc(8'hB8, 32'h0000_0000);
		chkb(hresp, 1'b0);
		$display("test unmapped done");
		complete_run();
	end
endmodule // qsr_status_top_tb
